// >>> verilog/dsw_frontend.sv
// Serial write front end of a 10-bit voltage DAC: shift register, code and mode registers.
// Assumes serial pins come from outside the clk_sys domain and are far slower than clk_sys.
//
// What this block does
// [R1] Frames assemble in a sixteen-bit shift register before anything executes.
// [R2] Data bits are sampled on falling edges of the serial clock.
// [R3] Bits are accepted only while active-low frame select is low.
// [R4] After the sixteenth falling edge, code and mode registers update.
// [R5] Frame select rising early aborts: shift cleared, code and mode kept.
// [R6] Code is 10-bit straight binary, zero to all ones.
// [R7] Word order MSB first: two ignored, two mode, ten code, two ignored.
// [R8] Mode 00 normal, 01 1k, 10 100k, 11 high-Z; code loaded from the frame in every mode.
// [R9] Reset loads zero code, held until a complete valid frame.
// [R10] Master must raise and lower frame select before the next frame.
// [R11] After execution, further clock edges ignored until select goes high then low.
`timescale 1ns/1ps
`include "dsw_map.svh"

module dsw_frontend
   import dsw_pkg::*;
#(
   parameter int FRAME_BITS = `DSW_FRAME_BITS,
   parameter int CODE_BITS = `DSW_CODE_BITS
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic frame_sel_n,
   input wire logic serial_clk,
   input wire logic serial_din,
   output logic [CODE_BITS-1:0] dac_code,
   output dsw_mode_t dac_mode,
   output logic mode_bit_high,
   output logic mode_bit_low,
   output logic update_pulse,
   output logic abort_pulse
);

   localparam int CNT_W = $clog2(FRAME_BITS + 1);
   localparam int PIN_SEL = 0;
   localparam int PIN_CLK = 1;
   localparam int PIN_DIN = 2;
   localparam int PIN_COUNT = 3;
   localparam logic [PIN_COUNT-1:0] PIN_RESET = 3'h1;

   // ----------------------------------------
   // Field decoders
   // ----------------------------------------
   function automatic dsw_mode_t mode_of(
      input logic [FRAME_BITS-1:0] w
   );
      mode_of = dsw_mode_t'({w[`DSW_MODE_HI_POS], w[`DSW_MODE_LO_POS]});
   endfunction : mode_of

   function automatic logic [CODE_BITS-1:0] code_of(
      input logic [FRAME_BITS-1:0] w
   );
      code_of = CODE_BITS'(w[`DSW_CODE_MSB:`DSW_CODE_LSB]);
   endfunction : code_of

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] pin_sync;
   logic [PIN_COUNT-1:0] pin_prev;

   assign pin_raw[PIN_SEL] = frame_sel_n;
   assign pin_raw[PIN_CLK] = serial_clk;
   assign pin_raw[PIN_DIN] = serial_din;

   for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
      logic meta_q;
      logic sync_q;
      logic prev_q;

      always_ff @(posedge clk_sys) begin
         if (srst) begin
            meta_q <= PIN_RESET[g];
         end else begin
            meta_q <= pin_raw[g];
         end
      end

      always_ff @(posedge clk_sys) begin
         if (srst) begin
            sync_q <= PIN_RESET[g];
         end else begin
            sync_q <= meta_q;
         end
      end

      always_ff @(posedge clk_sys) begin
         if (srst) begin
            prev_q <= PIN_RESET[g];
         end else begin
            prev_q <= sync_q;
         end
      end

      assign pin_sync[g] = sync_q;
      assign pin_prev[g] = prev_q;
   end

   logic sel_n_s;
   logic sel_prev;
   logic sclk_s;
   logic sclk_prev;
   logic din_s;
   logic sel_fall;
   logic sclk_fall;

   assign sel_n_s = pin_sync[PIN_SEL];
   assign sel_prev = pin_prev[PIN_SEL];
   assign sclk_s = pin_sync[PIN_CLK];
   assign sclk_prev = pin_prev[PIN_CLK];
   assign din_s = pin_sync[PIN_DIN];

   assign sel_fall = sel_prev & ~sel_n_s;
   assign sclk_fall = sclk_prev & ~sclk_s; // [R2]

   // ----------------------------------------
   // Frame sequencer
   // ----------------------------------------
   dsw_state_t state_q;
   logic [FRAME_BITS-1:0] shift_q;
   logic [CNT_W-1:0] count_q;
   logic [FRAME_BITS-1:0] word;
   logic last_bit;
   logic frame_start;
   logic frame_abort;
   logic frame_close;
   logic bit_take;
   logic exec;

   assign word = {shift_q[FRAME_BITS-2:0], din_s}; // [R7]
   assign last_bit = (count_q == CNT_W'(FRAME_BITS - 1));
   assign frame_start = (state_q == DSW_IDLE) && sel_fall; // [R3] [R10]
   assign frame_abort = (state_q == DSW_SHIFT) && sel_n_s; // [R5]
   assign frame_close = (state_q == DSW_DONE) && sel_n_s; // [R11]
   assign bit_take = (state_q == DSW_SHIFT) && !sel_n_s && sclk_fall; // [R2] [R3]
   assign exec = bit_take && last_bit; // [R4]

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_q <= DSW_IDLE;
      end else begin
         unique case (state_q)
            DSW_IDLE: begin
               if (frame_start) begin
                  state_q <= DSW_SHIFT;
               end
            end
            DSW_SHIFT: begin
               if (frame_abort) begin
                  state_q <= DSW_IDLE;
               end else if (exec) begin
                  state_q <= DSW_DONE;
               end
            end
            DSW_DONE: begin
               if (frame_close) begin
                  state_q <= DSW_IDLE;
               end
            end
            default: begin
               state_q <= DSW_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         shift_q <= '0;
      end else if (frame_start || frame_abort) begin // [R5]
         shift_q <= '0;
      end else if (bit_take) begin // [R1]
         shift_q <= word;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         count_q <= '0;
      end else if (frame_start || frame_abort || frame_close) begin
         count_q <= '0;
      end else if (bit_take) begin
         count_q <= count_q + CNT_W'(1);
      end
   end

   // ----------------------------------------
   // Code and mode registers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dac_code <= `DSW_CODE_RESET; // [R9]
      end else if (exec) begin
         dac_code <= code_of(word); // [R4] [R6]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dac_mode <= dsw_mode_t'(`DSW_MODE_RESET);
      end else if (exec) begin
         dac_mode <= mode_of(word); // [R8]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mode_bit_high <= 1'b0;
      end else if (exec) begin
         mode_bit_high <= word[`DSW_MODE_HI_POS];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mode_bit_low <= 1'b0;
      end else if (exec) begin
         mode_bit_low <= word[`DSW_MODE_LO_POS];
      end
   end

   // ----------------------------------------
   // Event pulses
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         update_pulse <= 1'b0;
      end else begin
         update_pulse <= exec;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         abort_pulse <= 1'b0;
      end else begin
         abort_pulse <= frame_abort; // [R5]
      end
   end

endmodule : dsw_frontend

// >>> verilog/dsw_map.svh
// Constants for the serial write front end: frame layout, reset values, timing.
// Assumes inclusion by bare name; definitions only.
`ifndef DSW_MAP_SVH
`define DSW_MAP_SVH
`define DSW_FRAME_BITS 16
`define DSW_CODE_BITS 10
`define DSW_MODE_HI_POS 13
`define DSW_MODE_LO_POS 12
`define DSW_CODE_MSB 11
`define DSW_CODE_LSB 2
`define DSW_CODE_RESET 10'h000
`define DSW_CODE_FULL 10'h3ff
`define DSW_MODE_RESET 2'h0
`define DSW_SYNC_HIGH_NS 33
`endif

// >>> verilog/dsw_pkg.sv
// Types for the serial write front end.
// Assumes nothing of its surroundings.
package dsw_pkg;
   typedef enum logic [1:0] {
      DSW_MODE_NORMAL = 2'h0,
      DSW_MODE_PD_1K = 2'h1,
      DSW_MODE_PD_100K = 2'h2,
      DSW_MODE_PD_HIZ = 2'h3
   } dsw_mode_t;
   typedef enum logic [1:0] {
      DSW_IDLE,
      DSW_SHIFT,
      DSW_DONE
   } dsw_state_t;
endpackage : dsw_pkg

// >>> tb/dsw_chk_asserts.sv
// Port checker for dsw_frontend.
// Bound into every dsw_frontend instance.
`timescale 1ns/1ps
module dsw_chk
   import dsw_pkg::*;
#(parameter int CODE_BITS = 10) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic frame_sel_n,
   input wire logic serial_clk,
   input wire logic serial_din,
   input wire logic [CODE_BITS-1:0] dac_code,
   input wire dsw_mode_t dac_mode,
   input wire logic mode_bit_high,
   input wire logic mode_bit_low,
   input wire logic update_pulse,
   input wire logic abort_pulse
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   upd_one_a: assert property (update_pulse |=> !update_pulse)
      else $error("update width");
   code_upd_a: assert property ($changed({dac_code, dac_mode}) |-> update_pulse)
      else $error("silent change");
   mode_bits_a: assert property (dac_mode == {mode_bit_high, mode_bit_low})
      else $error("mode bits");
   abort_keep_a: assert property (abort_pulse |-> $stable({dac_code, dac_mode}))
      else $error("abort changed");
   abort_excl_a: assert property (abort_pulse |-> !update_pulse)
      else $error("abort update");
   sel_idle_a: assert property (frame_sel_n [*8] |-> !update_pulse)
      else $error("update idle");
   sclk_idle_a: assert property ($stable(serial_clk) [*8] |=> $stable(dac_code))
      else $error("code no edge");
   rst_zero_a: assert property ($fell(srst) |-> dac_code == '0 && !update_pulse)
      else $error("reset code");
endmodule : dsw_chk
bind dsw_frontend dsw_chk #(.CODE_BITS(CODE_BITS)) u_dsw_chk (.*);

// >>> tb/dsw_master.sv
// Serial master model for the front end.
// Assumes one caller at a time.
`timescale 1ns/1ps
module dsw_master (
   input wire logic clk_sys,
   output logic frame_sel_n = 1'b1,
   output logic serial_clk = 1'b0,
   output logic serial_din = 1'b0
);
   // Sends n falling edges, word MSB first, then raises select
   // Serial clock runs 8 clk_sys high, 8 low, a 128 ns period
   task automatic send(input logic [15:0] w, input int n);
      @(posedge clk_sys);
      frame_sel_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      for (int i = 0; i < n; i++) begin
         serial_din <= (i < 16) ? w[15-i] : ~serial_din;
         serial_clk <= 1'b1;
         repeat (8) @(posedge clk_sys);
         serial_clk <= 1'b0;
         repeat (8) @(posedge clk_sys);
      end
      frame_sel_n <= 1'b1;
      serial_din <= ~serial_din;
      repeat (16) @(posedge clk_sys);
   endtask : send
endmodule : dsw_master

// >>> tb/test_dsw_frontend.sv
// Bench for dsw_frontend driven by a serial master model.
// Assumes dsw_pkg compiles first.
`timescale 1ns/1ps
module test_dsw_frontend;
   import dsw_pkg::*;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic frame_sel_n, serial_clk, serial_din, mode_bit_high, mode_bit_low;
   logic update_pulse, abort_pulse;
   logic [9:0] dac_code;
   dsw_mode_t dac_mode;
   int mismatches = 0;
   int samples_checked = 0;
   int updates = 0;
   int aborts = 0;
   initial forever #4 clk_sys = ~clk_sys;
   dsw_master i_dsw_master (
      .clk_sys(clk_sys),
      .frame_sel_n(frame_sel_n),
      .serial_clk(serial_clk),
      .serial_din(serial_din)
   );
   dsw_frontend i_dsw_frontend (
      .clk_sys(clk_sys),
      .srst(srst),
      .frame_sel_n(frame_sel_n),
      .serial_clk(serial_clk),
      .serial_din(serial_din),
      .dac_code(dac_code),
      .dac_mode(dac_mode),
      .mode_bit_high(mode_bit_high),
      .mode_bit_low(mode_bit_low),
      .update_pulse(update_pulse),
      .abort_pulse(abort_pulse)
   );
   always @(posedge clk_sys) begin
      if (update_pulse === 1'b1) updates++;
      if (abort_pulse === 1'b1) aborts++;
   end
   task automatic expect_count(input string name, input int exp, input int seen);
      samples_checked++;
      if (seen != exp) begin
         $display("Error %s expected %0d seen %0d", name, exp, seen);
         mismatches++;
      end
   endtask : expect_count
   task automatic expect_out(input logic [1:0] m, input logic [9:0] c);
      samples_checked++;
      if ({dac_mode, mode_bit_high, mode_bit_low, dac_code} !== {m, m, c}) begin
         $display("Error outputs expected %h seen %h", {m, m, c},
                  {dac_mode, mode_bit_high, mode_bit_low, dac_code});
         mismatches++;
      end
   endtask : expect_out
   task automatic t_modes;
      expect_out(2'h0, 10'h000);
      for (int m = 0; m < 4; m++) begin
         i_dsw_master.send({2'b11, 2'(m), 10'(10'h155 * m), 2'b11}, 16);
         expect_out(2'(m), 10'(10'h155 * m));
         expect_count("update_pulse", m + 1, updates);
      end
      expect_count("abort_pulse", 0, aborts);
   endtask : t_modes
   task automatic t_abort;
      i_dsw_master.send(16'h0000, 15);
      expect_out(2'h3, 10'h3ff);
      expect_count("abort_pulse", 1, aborts);
      expect_count("update_pulse", 4, updates);
      i_dsw_master.send(16'h2004, 20);
      expect_out(2'h2, 10'h001);
      expect_count("update_pulse", 5, updates);
      expect_count("abort_pulse", 1, aborts);
   endtask : t_abort
   task automatic give_verdict;
      $display("%0d checks, %0d errors", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      t_modes;
      t_abort;
      give_verdict;
   end
   initial begin
      #100000;
      mismatches++;
      give_verdict;
   end
endmodule : test_dsw_frontend
